// ===== design/pssp_pkg.sv
// Purpose: constants for the page size and stack pointer register block
// Assumes: 16-bit register port, word offsets chosen locally
// Notes:   offsets are register indices on the plain register port
package pssp_pkg;
  // register offsets
  localparam logic [3:0] OFF_CIRC_LOW  = 4'h0;
  localparam logic [3:0] OFF_CIRC_HIGH = 4'h1;
  localparam logic [3:0] OFF_CIRC_COEF = 4'h2;
  localparam logic [3:0] OFF_DP_OFFSET = 4'h3;
  localparam logic [3:0] OFF_DP_MAIN   = 4'h4;
  localparam logic [3:0] OFF_IO_PAGE   = 4'h5;
  localparam logic [3:0] OFF_DSTACK    = 4'h6;
  localparam logic [3:0] OFF_SSTACK    = 4'h7;
  localparam logic [3:0] OFF_STK_MAIN  = 4'h8;
  localparam logic [3:0] OFF_MODE      = 4'h9;
  // field widths and reset values
  localparam int PAGE_W = 7;
  localparam int IO_W   = 9;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [6:0]  RST_PAGE = 7'h00;
  localparam logic [8:0]  RST_IO   = 9'h000;
  localparam logic [15:0] ONE16    = 16'h0001;
  // mode register bit positions
  localparam int MODE_LEGACY = 0;
  localparam int MODE_CIRC   = 1;
  // stack operations from the instruction decoder
  typedef enum logic [2:0] {
    STK_NONE, STK_CALL, STK_PUSH, STK_RET, STK_POP
  } pssp_stkop_t;
endpackage

// ===== design/pssp_circ_addr.sv
// Purpose: circular address generation for one pointer
// Assumes: offset already below size when configured correctly
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module pssp_circ_addr (
  // pointer inputs
  input  wire logic [15:0] ptrOffset,
  input  wire logic [6:0]  ptrPage,
  input  wire logic [15:0] bufStart,
  input  wire logic [15:0] bufSize,
  input  wire logic        circEnable,
  // address output
  output logic      [22:0] addr
);
  logic [15:0] wrapped;
  // wrap offset into 0 .. size-1, then add start when circular
  always_comb begin
    wrapped = ptrOffset;
    if (bufSize != 16'h0000 && ptrOffset >= bufSize) begin
      wrapped = ptrOffset % bufSize;
    end
    if (circEnable) begin
      addr = {ptrPage, 16'h0000} + {7'h00, bufStart} + {7'h00, wrapped};
    end else begin
      addr = {ptrPage, ptrOffset};
    end
  end
endmodule
`default_nettype wire

// ===== design/pssp_regs.sv
// Purpose: circular size, data page, io page and stack pointer registers
// Assumes: decoder issues at most one stack op and one ext write per cycle
// Notes:   software port has one-cycle read latency and never stalls
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pssp_regs (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // software register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdata,
  // dedicated instruction writes of extended registers
  input  wire logic        extDataPageWr,
  input  wire logic        extDataStackWr,
  input  wire logic        extSysStackWr,
  input  wire logic [22:0] extWdata,
  // stack operation from decoder
  input  wire pssp_pkg::pssp_stkop_t stackOp,
  // address operands
  input  wire logic [15:0] absImmediate,
  input  wire logic [6:0]  ioWordOffset,
  input  wire logic [2:0]  auxSelect,
  input  wire logic        useCoef,
  input  wire logic [15:0] ptrOffset,
  input  wire logic [6:0]  ptrPage,
  input  wire logic [15:0] bufStart,
  // generated addresses
  output logic      [22:0] ext_data_page,
  output logic      [22:0] pageDirectBase,
  output logic      [22:0] absAddr,
  output logic      [15:0] ioAddr,
  output logic      [22:0] ext_data_stack_ptr,
  output logic      [22:0] ext_system_stack_ptr,
  output logic      [22:0] dataStackPushAddr,
  output logic      [22:0] sysStackPushAddr,
  output logic      [22:0] stackDirectBase,
  output logic      [15:0] selectedSize,
  output logic      [22:0] circAddr
);
  typedef struct packed {
    logic [15:0] circSizeLow;
    logic [15:0] circSizeHigh;
    logic [15:0] circSizeCoef;
    logic [15:0] dataPageOffset;
    logic [6:0]  dataPageMain;
    logic [8:0]  ioPageSelect;
    logic [15:0] dataStackPtr;
    logic [15:0] systemStackPtr;
    logic [6:0]  stackPageMain;
    logic        legacyCompatMode;
    logic        circEnable;
    logic [15:0] rdata;
  } pssp_state_t;

  pssp_state_t st;
  pssp_state_t next_st;

  // modulo-64K step, no carry out into the page
  function automatic logic [15:0] pssp_step(input logic [15:0] v,
                                            input logic dec);
    pssp_step = dec ? v - pssp_pkg::ONE16 : v + pssp_pkg::ONE16;
  endfunction

  // register read mux
  function automatic logic [15:0] pssp_read(input pssp_state_t s,
                                            input logic [3:0] a);
    case (a)
      pssp_pkg::OFF_CIRC_LOW:  pssp_read = s.circSizeLow;
      pssp_pkg::OFF_CIRC_HIGH: pssp_read = s.circSizeHigh;
      pssp_pkg::OFF_CIRC_COEF: pssp_read = s.circSizeCoef;
      pssp_pkg::OFF_DP_OFFSET: pssp_read = s.dataPageOffset;
      pssp_pkg::OFF_DP_MAIN:   pssp_read = {9'h000, s.dataPageMain};
      pssp_pkg::OFF_IO_PAGE:   pssp_read = {7'h00, s.ioPageSelect};
      pssp_pkg::OFF_DSTACK:    pssp_read = s.dataStackPtr;
      pssp_pkg::OFF_SSTACK:    pssp_read = s.systemStackPtr;
      pssp_pkg::OFF_STK_MAIN:  pssp_read = {9'h000, s.stackPageMain};
      pssp_pkg::OFF_MODE:      pssp_read = {14'h0000, s.circEnable,
                                            s.legacyCompatMode};
      default:                 pssp_read = 16'h0000;
    endcase
  endfunction

  // next state: software writes, instruction writes, stack ops
  always_comb begin
    next_st = st;
    next_st.rdata = regRead ? pssp_read(st, regAddr) : 16'h0000;
    if (regWrite) begin
      case (regAddr)
        pssp_pkg::OFF_CIRC_LOW:  next_st.circSizeLow = regWdata;
        pssp_pkg::OFF_CIRC_HIGH: next_st.circSizeHigh = regWdata;
        pssp_pkg::OFF_CIRC_COEF: next_st.circSizeCoef = regWdata;
        pssp_pkg::OFF_DP_OFFSET: next_st.dataPageOffset = regWdata;
        pssp_pkg::OFF_DP_MAIN:
          next_st.dataPageMain = regWdata[pssp_pkg::PAGE_W-1:0];
        pssp_pkg::OFF_IO_PAGE:
          next_st.ioPageSelect = regWdata[pssp_pkg::IO_W-1:0];
        pssp_pkg::OFF_DSTACK:    next_st.dataStackPtr = regWdata;
        pssp_pkg::OFF_SSTACK:    next_st.systemStackPtr = regWdata;
        pssp_pkg::OFF_STK_MAIN:
          next_st.stackPageMain = regWdata[pssp_pkg::PAGE_W-1:0];
        pssp_pkg::OFF_MODE: begin
          next_st.legacyCompatMode = regWdata[pssp_pkg::MODE_LEGACY];
          next_st.circEnable = regWdata[pssp_pkg::MODE_CIRC];
        end
        default: ;
      endcase
    end
    // extended writes through dedicated instructions only
    if (extDataPageWr) begin
      {next_st.dataPageMain, next_st.dataPageOffset} = extWdata;
    end
    if (extDataStackWr) begin
      {next_st.stackPageMain, next_st.dataStackPtr} = extWdata;
    end
    if (extSysStackWr) begin
      {next_st.stackPageMain, next_st.systemStackPtr} = extWdata;
    end
    // stack pointer updates; page field never changes here
    case (stackOp)
      pssp_pkg::STK_CALL: begin
        next_st.dataStackPtr = pssp_step(st.dataStackPtr, 1'b1);
        next_st.systemStackPtr = pssp_step(st.systemStackPtr, 1'b1);
      end
      pssp_pkg::STK_PUSH:
        next_st.dataStackPtr = pssp_step(st.dataStackPtr, 1'b1);
      pssp_pkg::STK_RET: begin
        next_st.dataStackPtr = pssp_step(st.dataStackPtr, 1'b0);
        next_st.systemStackPtr = pssp_step(st.systemStackPtr, 1'b0);
      end
      pssp_pkg::STK_POP:
        next_st.dataStackPtr = pssp_step(st.dataStackPtr, 1'b0);
      default: ;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // data page and io page addresses
  always_comb begin
    ext_data_page = {st.dataPageMain, st.dataPageOffset};
    pageDirectBase = ext_data_page;
    absAddr = {st.dataPageMain, absImmediate};
    ioAddr = {st.ioPageSelect, ioWordOffset};
  end

  // stack addresses; push targets use pre-decremented pointers
  always_comb begin
    ext_data_stack_ptr = {st.stackPageMain, st.dataStackPtr};
    ext_system_stack_ptr = {st.stackPageMain, st.systemStackPtr};
    dataStackPushAddr = {st.stackPageMain,
                         pssp_step(st.dataStackPtr, 1'b1)};
    sysStackPushAddr = {st.stackPageMain,
                        pssp_step(st.systemStackPtr, 1'b1)};
    stackDirectBase = ext_data_stack_ptr;
  end

  // size register selection per pointer
  always_comb begin
    if (useCoef) begin
      selectedSize = st.circSizeCoef;
    end else if (st.legacyCompatMode || !auxSelect[2]) begin
      selectedSize = st.circSizeLow;
    end else begin
      selectedSize = st.circSizeHigh;
    end
  end

  // circular address unit
  pssp_circ_addr u_circ (
    .ptrOffset  (ptrOffset),
    .ptrPage    (ptrPage),
    .bufStart   (bufStart),
    .bufSize    (selectedSize),
    .circEnable (st.circEnable),
    .addr       (circAddr)
  );

  // read data output
  assign regRdata = st.rdata;

  // push moves the data stack pointer down by one
  a_push_decrement: assert property (
    @(posedge clk_sys) disable iff (reset)
    (stackOp == pssp_pkg::STK_PUSH && !regWrite && !extDataStackWr)
      |=> st.dataStackPtr == $past(st.dataStackPtr) - pssp_pkg::ONE16)
    else $error("push did not decrement data stack pointer");
  // push leaves the system stack pointer alone
  a_push_sys_kept: assert property (
    @(posedge clk_sys) disable iff (reset)
    (stackOp == pssp_pkg::STK_PUSH && !regWrite && !extSysStackWr)
      |=> $stable(st.systemStackPtr))
    else $error("push changed system stack pointer");
  // pushed word lands where the extended data pointer then points
  a_push_slot: assert property (
    @(posedge clk_sys) disable iff (reset)
    (stackOp == pssp_pkg::STK_PUSH && !extDataStackWr && !extSysStackWr
     && !(regWrite && regAddr == pssp_pkg::OFF_STK_MAIN))
      |=> ext_data_stack_ptr == $past(dataStackPushAddr))
    else $error("data stack pointer misses pushed slot");

  // call moves both stack pointers down by one
  a_call_both: assert property (
    @(posedge clk_sys) disable iff (reset)
    (stackOp == pssp_pkg::STK_CALL && !regWrite && !extDataStackWr
     && !extSysStackWr)
      |=> st.systemStackPtr == $past(st.systemStackPtr) - pssp_pkg::ONE16
          && st.dataStackPtr == $past(st.dataStackPtr) - pssp_pkg::ONE16)
    else $error("call did not decrement both stack pointers");
  // call lands the system word where the extended pointer then points
  a_call_slot: assert property (
    @(posedge clk_sys) disable iff (reset)
    (stackOp == pssp_pkg::STK_CALL && !extDataStackWr && !extSysStackWr
     && !(regWrite && regAddr == pssp_pkg::OFF_STK_MAIN))
      |=> ext_system_stack_ptr == $past(sysStackPushAddr))
    else $error("system stack pointer misses pushed slot");
  // return moves both stack pointers up by one
  a_ret_both: assert property (
    @(posedge clk_sys) disable iff (reset)
    (stackOp == pssp_pkg::STK_RET && !regWrite && !extDataStackWr
     && !extSysStackWr)
      |=> st.systemStackPtr == $past(st.systemStackPtr) + pssp_pkg::ONE16
          && st.dataStackPtr == $past(st.dataStackPtr) + pssp_pkg::ONE16)
    else $error("return did not increment both stack pointers");
  // pop moves the data stack pointer up by one
  a_pop_increment: assert property (
    @(posedge clk_sys) disable iff (reset)
    (stackOp == pssp_pkg::STK_POP && !regWrite && !extDataStackWr)
      |=> st.dataStackPtr == $past(st.dataStackPtr) + pssp_pkg::ONE16)
    else $error("pop did not increment data stack pointer");
  // pop leaves the system stack pointer alone
  a_pop_data_only: assert property (
    @(posedge clk_sys) disable iff (reset)
    (stackOp == pssp_pkg::STK_POP && !regWrite && !extSysStackWr)
      |=> $stable(st.systemStackPtr))
    else $error("pop changed system stack pointer");
  // stack steps never carry into the shared page
  a_page_no_carry: assert property (
    @(posedge clk_sys) disable iff (reset)
    (stackOp != pssp_pkg::STK_NONE && !regWrite && !extDataStackWr
     && !extSysStackWr) |=> $stable(st.stackPageMain))
    else $error("stack arithmetic changed stack page");

  // either extended stack write sets the shared page
  a_ext_sp_page: assert property (
    @(posedge clk_sys) disable iff (reset)
    extDataStackWr && !extSysStackWr
      |=> st.stackPageMain == $past(extWdata[22:16]))
    else $error("extended stack write did not set stack page");
  a_ext_ssp_page: assert property (
    @(posedge clk_sys) disable iff (reset)
    extSysStackWr |=> st.stackPageMain == $past(extWdata[22:16]))
    else $error("system stack write did not set stack page");
  // extended data page write loads both page parts at once
  a_xdp_write: assert property (
    @(posedge clk_sys) disable iff (reset)
    extDataPageWr |=> ext_data_page == $past(extWdata))
    else $error("extended data page write lost");
  // mapped main page write keeps only the page field
  a_dp_main_write: assert property (
    @(posedge clk_sys) disable iff (reset)
    (regWrite && regAddr == pssp_pkg::OFF_DP_MAIN && !extDataPageWr)
      |=> st.dataPageMain == $past(regWdata[pssp_pkg::PAGE_W-1:0]))
    else $error("main page write lost");
  // absolute address puts the main page above the immediate
  a_abs_addr: assert property (
    @(posedge clk_sys) disable iff (reset)
    absAddr[22:16] == st.dataPageMain && absAddr[15:0] == absImmediate)
    else $error("absolute address not formed from main page");

  // io page keeps bits 8..0 of a mapped write
  a_io_write: assert property (
    @(posedge clk_sys) disable iff (reset)
    (regWrite && regAddr == pssp_pkg::OFF_IO_PAGE)
      |=> st.ioPageSelect == $past(regWdata[pssp_pkg::IO_W-1:0]))
    else $error("io page write lost");
  // io page reads back with the ignored bits low
  a_io_high_zero: assert property (
    @(posedge clk_sys) disable iff (reset)
    regRead && regAddr == pssp_pkg::OFF_IO_PAGE
      |=> regRdata[15:9] == 7'h00)
    else $error("io page upper bits not zero");

  // size registers keep all 16 bits of a write
  a_size_write: assert property (
    @(posedge clk_sys) disable iff (reset)
    (regWrite && regAddr == pssp_pkg::OFF_CIRC_COEF)
      |=> st.circSizeCoef == $past(regWdata))
    else $error("coefficient size write lost");
  // legacy mode serves every aux pointer from the low size
  a_legacy_size: assert property (
    @(posedge clk_sys) disable iff (reset)
    st.legacyCompatMode && !useCoef |-> selectedSize == st.circSizeLow)
    else $error("legacy mode did not use low size register");
  // native mode serves pointers 4-7 from the high size
  a_native_size: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!st.legacyCompatMode && !useCoef && auxSelect[2])
      |-> selectedSize == st.circSizeHigh)
    else $error("native mode did not use high size register");
  // coefficient pointer always uses its own size register
  a_coef_size: assert property (
    @(posedge clk_sys) disable iff (reset)
    useCoef |-> selectedSize == st.circSizeCoef)
    else $error("coefficient pointer did not use its size register");
  // linear pointers pass straight through with no start address
  a_linear_addr: assert property (
    @(posedge clk_sys) disable iff (reset)
    !st.circEnable |-> circAddr == {ptrPage, ptrOffset})
    else $error("start address added without circular mode");
  // circular offset stays below the buffer size
  a_circ_range: assert property (
    @(posedge clk_sys) disable iff (reset)
    (st.circEnable && selectedSize != 16'h0000)
      |-> circAddr - {ptrPage, 16'h0000} - {7'h00, bufStart}
          < {7'h00, selectedSize})
    else $error("circular offset outside buffer");
endmodule
`default_nettype wire

// ===== testbench/tb_page_size_and_stack_pointers.sv
// Purpose: self-checking bench for the page size and stack pointer block
// Assumes: one-cycle read latency, stack ops taken one per cycle
// Notes:   seeded random values mixed with a few fixed values; stack pointers start mid-range and never wrap
`timescale 1ns/1ps
`default_nettype none
module tb_page_size_and_stack_pointers;
  // driven inputs
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic        extDataPageWr = 1'b0;
  logic        extDataStackWr = 1'b0;
  logic        extSysStackWr = 1'b0;
  logic [22:0] extWdata = 23'h000000;
  pssp_pkg::pssp_stkop_t stackOp = pssp_pkg::STK_NONE;
  logic [15:0] absImmediate = 16'h0000;
  logic [6:0]  ioWordOffset = 7'h00;
  logic [2:0]  auxSelect = 3'h0;
  logic        useCoef = 1'b0;
  logic [15:0] ptrOffset = 16'h0000;
  logic [6:0]  ptrPage = 7'h00;
  logic [15:0] bufStart = 16'h0000;
  // observed outputs
  logic [15:0] regRdata, ioAddr, selectedSize;
  logic [22:0] ext_data_page, pageDirectBase, absAddr, circAddr;
  logic [22:0] ext_data_stack_ptr, ext_system_stack_ptr, stackDirectBase;
  logic [22:0] dataStackPushAddr, sysStackPushAddr;
  // bench state
  logic [15:0] mdl [0:15];
  logic [15:0] sz, off, d;
  logic [22:0] ex;
  int          i, seed, n_errors, check_count;

  always #5 clk_sys = ~clk_sys;

  pssp_regs u_dut (.clk_sys, .reset, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .extDataPageWr, .extDataStackWr, .extSysStackWr,
    .extWdata, .stackOp, .absImmediate, .ioWordOffset, .auxSelect, .useCoef,
    .ptrOffset, .ptrPage, .bufStart, .ext_data_page, .pageDirectBase,
    .absAddr, .ioAddr, .ext_data_stack_ptr, .ext_system_stack_ptr,
    .dataStackPushAddr, .sysStackPushAddr, .stackDirectBase, .selectedSize,
    .circAddr);

  // compare and count
  task automatic chk(input string nm, input logic [22:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [15:0] r16();
    return 16'($random(seed));
  endfunction
  // mapped width of each register index
  function automatic logic [15:0] msk(input logic [3:0] a);
    return (a == 4'h4 || a == 4'h8) ? 16'h007F :
           (a == 4'h5) ? 16'h01FF : (a == 4'h9) ? 16'h0003 :
           (a > 4'h9) ? 16'h0000 : 16'hFFFF;
  endfunction
  // bus write and read with check
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    mdl[a] = v & msk(a);
  endtask
  task automatic rdc(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk("rdata", regRdata, mdl[a]);
  endtask
  // stack operation and stack address checks
  task automatic chkstk();
    logic [6:0] pg;
    #1 pg = mdl[8][6:0];
    chk("xsp", ext_data_stack_ptr, {pg, mdl[6]});
    chk("ext_system_stack_ptr", ext_system_stack_ptr, {pg, mdl[7]});
    chk("dpush", dataStackPushAddr, {pg, mdl[6] - 16'h0001});
    chk("spush", sysStackPushAddr, {pg, mdl[7] - 16'h0001});
    chk("spbase", stackDirectBase, {pg, mdl[6]});
  endtask
  task automatic op(input pssp_pkg::pssp_stkop_t o);
    @(posedge clk_sys);
    stackOp <= o;
    @(posedge clk_sys);
    stackOp <= pssp_pkg::STK_NONE;
    if (o == pssp_pkg::STK_CALL || o == pssp_pkg::STK_PUSH) mdl[6] -= 16'h0001;
    if (o == pssp_pkg::STK_CALL) mdl[7] -= 16'h0001;
    if (o == pssp_pkg::STK_RET || o == pssp_pkg::STK_POP) mdl[6] += 16'h0001;
    if (o == pssp_pkg::STK_RET) mdl[7] += 16'h0001;
    chkstk();
  endtask
  // extended write: 0 data page, 1 data stack, 2 system stack
  task automatic ext(input int k, input logic [22:0] w);
    @(posedge clk_sys);
    extWdata <= w;
    extDataPageWr <= (k == 0);
    extDataStackWr <= (k == 1);
    extSysStackWr <= (k == 2);
    @(posedge clk_sys);
    {extDataPageWr, extDataStackWr, extSysStackWr} <= 3'b000;
    mdl[k == 0 ? 4 : 8] = {9'h000, w[22:16]};
    mdl[k == 0 ? 3 : k + 5] = w[15:0];
  endtask
  // verdict
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    seed = 3;
    for (i = 0; i < 16; i++) mdl[i] = 16'h0000;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    for (i = 0; i < 16; i++) rdc(4'(i));
    $display("test reset values done");
    for (i = 0; i < 30; i++) begin
      d = 16'($unsigned($random(seed)) % 9);
      wr(d[3:0], r16());
      rdc(d[3:0]);
    end
    wr(4'hB, 16'hFFFF);
    rdc(4'hB);
    $display("test register access done");
    for (i = 0; i < 8; i++) begin
      wr(4'h3, r16());
      wr(4'h4, r16());
      wr(4'h5, r16());
      @(posedge clk_sys);
      absImmediate <= r16();
      ioWordOffset <= 7'(r16());
      #1 chk("xdp", ext_data_page, {mdl[4][6:0], mdl[3]});
      chk("direct", pageDirectBase, {mdl[4][6:0], mdl[3]});
      chk("abs", absAddr, {mdl[4][6:0], absImmediate});
      chk("io", ioAddr, {7'h00, mdl[5][8:0], ioWordOffset});
    end
    $display("test page addresses done");
    // every pointer under each legacy and circular mode
    for (i = 0; i < 36; i++) begin
      if (i % 9 == 0) begin
        wr(4'h0, i == 0 ? 16'hFFFF : r16());
        wr(4'h1, r16());
        wr(4'h2, r16());
        wr(4'h9, 16'(i / 9));
        rdc(4'h9);
      end
      @(posedge clk_sys);
      auxSelect <= 3'(i % 9);
      useCoef <= (i % 9 == 8);
      ptrPage <= 7'(r16());
      bufStart <= r16() & 16'h7FFF;
      ptrOffset <= r16() & 16'h7FFF;
      #1 sz = (i % 9 == 8) ? mdl[2] :
              (mdl[9][0] || i % 9 < 4) ? mdl[0] : mdl[1];
      chk("size", selectedSize, sz);
      off = (sz != 0 && ptrOffset >= sz) ? ptrOffset % sz : ptrOffset;
      ex = {ptrPage, 16'h0000} + bufStart + off;
      if (!mdl[9][1]) ex = {ptrPage, ptrOffset};
      chk("circ", circAddr, ex);
    end
    $display("test circular sizes done");
    // pointers start mid-range so no stack step ever wraps
    wr(4'h6, 16'h8001);
    wr(4'h7, 16'h8000);
    wr(4'h8, 16'h0055);
    chkstk();
    op(pssp_pkg::STK_CALL);
    op(pssp_pkg::STK_CALL);
    op(pssp_pkg::STK_RET);
    op(pssp_pkg::STK_RET);
    for (i = 0; i < 40; i++) begin
      d = 16'(1 + $unsigned($random(seed)) % 4);
      op(pssp_pkg::pssp_stkop_t'(d[2:0]));
    end
    for (i = 6; i < 9; i++) rdc(4'(i));
    $display("test stack operations done");
    ext(0, 23'($random(seed)));
    rdc(4'h3);
    rdc(4'h4);
    #1 chk("xdp", ext_data_page, {mdl[4][6:0], mdl[3]});
    for (i = 1; i < 3; i++) begin
      ext(i, 23'($random(seed)));
      chkstk();
      rdc(4'h8);
      rdc(4'(i + 5));
    end
    $display("test extended writes done");
    // asynchronous reset in mid-run returns every register to zero
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    for (i = 0; i < 16; i++) mdl[i] = 16'h0000;
    #1 chk("xdp", ext_data_page, 23'h000000);
    chkstk();
    for (i = 0; i < 10; i++) rdc(4'(i));
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
